//--- logic/lpd_low_power.sv
`timescale 1ns/1ps
`default_nettype none
`include "lpd_map.svh"
module lpd_low_power (
    input wire logic i_clk,          // 10 MHz core clock
    input wire logic i_rst_n,        // Async reset, active low
    input wire logic i_cke,          // Clock enable from controller
    input wire logic i_cs_n,         // Chip select, active low
    input wire logic i_ras_n,        // Row strobe, active low
    input wire logic i_cas_n,        // Column strobe, active low
    input wire logic i_we_n,         // Write enable, active low
    input wire logic i_banks_open,   // Any bank open after commands
    input wire logic i_busy,         // Commands still completing
    input wire logic i_dll_disable,  // Mode bit: DLL off when high
    input wire logic i_dn_fast_exit, // Mode bit: fast exit when high
    output lpd_pkg::lpd_state_e o_state, // Low-power state
    output logic o_self_refresh,     // In self-refresh
    output logic o_power_down,       // In any power-down mode
    output logic o_dn_active,        // In active power-down
    output logic o_dll_enable,       // DLL running
    output logic o_dll_reset,        // DLL reset pulse at self-refresh exit, DLL enabled
    output logic o_int_clk_en,       // Internal clock enabled
    output logic o_buf_en,           // Input and output buffers on
    output logic o_cmd_rcv_en,       // Command receivers on
    output logic o_ctrl_ignore,      // Control inputs ignored
    output logic o_refresh_pulse     // Internal refresh request
);
    import lpd_pkg::*;

    localparam int AST_REF_WIN = `LPD_TCKE_CYC;
    localparam int AST_CPDED_WIN = `LPD_TCPDED_CYC + 2;

    // ======================================================
    // Reset release
    logic rst_meta_ff;
    logic rst_sync_ff;
    logic rst_n;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end
    assign rst_n = rst_sync_ff;

    // ======================================================
    // Command decode
    logic nop_cmd;
    logic self_refresh_entry_cmd;
    logic low_power_idle_entry;

    assign nop_cmd = i_cs_n || (i_ras_n && i_cas_n && i_we_n);
    assign self_refresh_entry_cmd = !i_cs_n && !i_ras_n && !i_cas_n &&
        i_we_n && !i_cke;
    assign low_power_idle_entry = !i_cke && nop_cmd;

    // ======================================================
    // Timers
    lpd_tmr_if sr_tmr ();
    lpd_tmr_if dn_tmr ();

    lpd_timer u_sr_timer (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .tmr(sr_tmr.tmr)
    );

    lpd_timer u_dn_timer (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .tmr(dn_tmr.tmr)
    );

    // ======================================================
    // State
    lpd_state_e state_ff;
    lpd_state_e nxt_state;
    lpd_state_e dn_class;
    logic in_dn;
    logic nxt_in_dn;

    // Mode is settled only once in-progress commands finish
    assign dn_class = i_banks_open ? LPD_ST_DN_ACT :
        (i_dn_fast_exit ? LPD_ST_DN_FAST : LPD_ST_DN_SLOW);
    assign in_dn = (state_ff == LPD_ST_DN_ACT) ||
        (state_ff == LPD_ST_DN_FAST) || (state_ff == LPD_ST_DN_SLOW);
    assign nxt_in_dn = (nxt_state == LPD_ST_DN_ACT) ||
        (nxt_state == LPD_ST_DN_FAST) || (nxt_state == LPD_ST_DN_SLOW);

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            LPD_ST_IDLE: begin
                if (self_refresh_entry_cmd) begin
                    nxt_state = LPD_ST_SREF;
                end else if (low_power_idle_entry) begin
                    nxt_state = dn_class;
                end
            end
            LPD_ST_SREF: begin
                // Every control but CKE is don't care here
                if (i_cke) begin
                    nxt_state = LPD_ST_IDLE;
                end
            end
            LPD_ST_DN_ACT, LPD_ST_DN_FAST, LPD_ST_DN_SLOW: begin
                if (i_cke && nop_cmd) begin
                    nxt_state = LPD_ST_IDLE;
                end else if (i_busy) begin
                    nxt_state = dn_class;
                end
            end
            default: begin
                nxt_state = LPD_ST_IDLE;
            end
        endcase
    end

    // ======================================================
    // Timer control
    always_comb begin
        sr_tmr.load = 1'b0;
        sr_tmr.value = lpd_cnt_t'(`LPD_TREFI_CYC);
        if (state_ff != LPD_ST_SREF && nxt_state == LPD_ST_SREF) begin
            sr_tmr.load = 1'b1;
            sr_tmr.value = lpd_cnt_t'(`LPD_TCKE_LOAD);
        end else if (state_ff == LPD_ST_SREF && sr_tmr.done) begin
            sr_tmr.load = 1'b1;
        end
        dn_tmr.load = !in_dn && nxt_in_dn;
        dn_tmr.value = lpd_cnt_t'(`LPD_TCPDED_CYC);
    end

    // ======================================================
    // Outputs, all registered; all but the refresh pulse from the next state
    logic nxt_dll_enable;
    logic nxt_dll_reset;
    logic nxt_cmd_rcv_en;
    logic nxt_refresh;

    always_comb begin
        nxt_dll_enable = !i_dll_disable;
        if (nxt_state == LPD_ST_SREF || nxt_state == LPD_ST_DN_SLOW) begin
            nxt_dll_enable = 1'b0;
        end
        nxt_dll_reset = (state_ff == LPD_ST_SREF) &&
            (nxt_state != LPD_ST_SREF) && !i_dll_disable;
        nxt_cmd_rcv_en = 1'b1;
        if (nxt_state == LPD_ST_SREF) begin
            nxt_cmd_rcv_en = 1'b0;
        end else if (nxt_in_dn && in_dn) begin
            // NOPs still land while tCPDED runs
            nxt_cmd_rcv_en = o_cmd_rcv_en && !dn_tmr.done;
        end
        nxt_refresh = (state_ff == LPD_ST_SREF) && sr_tmr.done;
    end

    // Async reset also pulls the device out of power-down
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= LPD_ST_IDLE;
            o_state <= LPD_ST_IDLE;
            o_self_refresh <= 1'b0;
            o_power_down <= 1'b0;
            o_dn_active <= 1'b0;
            o_dll_enable <= 1'b0;
            o_dll_reset <= 1'b0;
            o_int_clk_en <= 1'b1;
            o_buf_en <= 1'b1;
            o_cmd_rcv_en <= 1'b1;
            o_ctrl_ignore <= 1'b0;
            o_refresh_pulse <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            o_state <= nxt_state;
            o_self_refresh <= nxt_state == LPD_ST_SREF;
            o_power_down <= nxt_in_dn;
            o_dn_active <= nxt_state == LPD_ST_DN_ACT;
            o_dll_enable <= nxt_dll_enable;
            o_dll_reset <= nxt_dll_reset;
            o_int_clk_en <= nxt_state != LPD_ST_SREF;
            o_buf_en <= nxt_state == LPD_ST_IDLE;
            o_cmd_rcv_en <= nxt_cmd_rcv_en;
            o_ctrl_ignore <= nxt_state == LPD_ST_SREF;
            o_refresh_pulse <= nxt_refresh;
        end
    end

    // ======================================================
    // Checks
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!rst_n);

    AST_SRE_DECODE: assert property (
        (state_ff == LPD_ST_IDLE && self_refresh_entry_cmd)
        |=> (o_self_refresh && o_state == LPD_ST_SREF))
        else $error("Self-refresh entry not taken");

    AST_SR_DLL_OFF: assert property (
        o_self_refresh |-> !o_dll_enable)
        else $error("DLL running in self-refresh");

    AST_SRX_DLL_RESET: assert property (
        (state_ff == LPD_ST_SREF && i_cke && !i_dll_disable)
        |=> (o_dll_reset && o_dll_enable && !o_self_refresh)
        ##1 !o_dll_reset)
        else $error("DLL reset pulse missing at self-refresh exit");

    AST_SR_HOLD: assert property (
        (state_ff == LPD_ST_SREF && !i_cke)
        |=> (o_self_refresh && !o_int_clk_en && o_ctrl_ignore))
        else $error("Self-refresh left without CKE high");

    AST_SR_FIRST_REF: assert property (
        $rose(o_self_refresh)
        |-> ##[1:AST_REF_WIN] (o_refresh_pulse || !o_self_refresh))
        else $error("No internal refresh within tCKE");

    AST_DN_ENTRY: assert property (
        (state_ff == LPD_ST_IDLE && low_power_idle_entry &&
        !self_refresh_entry_cmd) |=> o_power_down)
        else $error("Power-down entry not taken");

    AST_DN_EXIT: assert property (
        (in_dn && i_cke && nop_cmd)
        |=> (o_state == LPD_ST_IDLE && o_buf_en && o_cmd_rcv_en))
        else $error("Power-down exit not taken");

    AST_DN_CLASS: assert property (
        (in_dn && !i_cke && !i_busy && !$past(i_busy))
        |=> (o_dn_active == $past(o_dn_active)))
        else $error("Power-down mode changed after commands settled");

    AST_DN_ACT_MODE: assert property (
        (state_ff == LPD_ST_IDLE && low_power_idle_entry &&
        i_banks_open) |=> o_dn_active)
        else $error("Open bank did not give active power-down");

    AST_RCV_OFF: assert property (
        $rose(o_power_down) |-> (o_cmd_rcv_en && !o_buf_en)
        ##[1:AST_CPDED_WIN] (!o_cmd_rcv_en || !o_power_down))
        else $error("Command receivers not gated after tCPDED");

    AST_DLL_MODE: assert property (
        o_power_down |-> (o_dll_enable ==
        (!i_dll_disable && o_state != LPD_ST_DN_SLOW)))
        else $error("DLL state wrong for power-down mode");
endmodule
`default_nettype wire

//--- logic/lpd_map.svh
`ifndef LPD_MAP_SVH
`define LPD_MAP_SVH
// ==========================================================
// Clock and timing figures
`define LPD_CLK_NS 100
`define LPD_TCKE_NS 5
`define LPD_TCPDED_NCK 1
`define LPD_TREFI_NS 7800
// Least times round up, longest times round down
`define LPD_TCKE_CYC ((`LPD_TCKE_NS + `LPD_CLK_NS - 1) / `LPD_CLK_NS)
`define LPD_TCPDED_CYC (`LPD_TCPDED_NCK)
`define LPD_TREFI_CYC (`LPD_TREFI_NS / `LPD_CLK_NS)
// The refresh output is registered, so the first load is one short
`define LPD_TCKE_LOAD (`LPD_TCKE_CYC - 1)
// ==========================================================
// Timer width
`define LPD_TMR_W 8
`define LPD_TMR_ZERO 8'h00
`define LPD_TMR_ONE 8'h01
`endif

//--- logic/lpd_pkg.sv
`default_nettype none
package lpd_pkg;
    // ======================================================
    // Low-power state, one-hot
    typedef enum logic [4:0] {
        LPD_ST_IDLE = 5'h01,
        LPD_ST_SREF = 5'h02,
        LPD_ST_DN_ACT = 5'h04,
        LPD_ST_DN_FAST = 5'h08,
        LPD_ST_DN_SLOW = 5'h10
    } lpd_state_e;
    typedef logic [7:0] lpd_cnt_t;
endpackage
`default_nettype wire

//--- logic/lpd_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "lpd_map.svh"
module lpd_timer (
    input wire logic i_clk,   // Core clock
    input wire logic i_rst_n, // Synchronised reset, active low
    lpd_tmr_if.tmr tmr        // Load, value and expiry
);
    import lpd_pkg::*;
    lpd_cnt_t cnt_ff;
    lpd_cnt_t nxt_cnt;
    logic armed_ff;
    logic nxt_armed;

    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_armed = armed_ff;
        if (tmr.load) begin
            nxt_cnt = tmr.value;
            nxt_armed = 1'b1;
        end else if (cnt_ff != `LPD_TMR_ZERO) begin
            nxt_cnt = cnt_ff - `LPD_TMR_ONE;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_ff <= `LPD_TMR_ZERO;
            armed_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            armed_ff <= nxt_armed;
        end
    end

    // Stays high until reloaded
    assign tmr.done = armed_ff && (cnt_ff == `LPD_TMR_ZERO);
endmodule
`default_nettype wire

//--- logic/lpd_tmr_if.sv
`timescale 1ns/1ps
`default_nettype none
interface lpd_tmr_if;
    import lpd_pkg::*;
    logic load;
    lpd_cnt_t value;
    logic done;
    modport ctl (output load, output value, input done);
    modport tmr (input load, input value, output done);
endinterface
`default_nettype wire

//--- sim/ddr3_self_refresh_power_down_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "lpd_map.svh"
module ddr3_self_refresh_power_down_tb;
    import lpd_pkg::*;
    logic clk = 1'b0;
    logic rst_n, cke, cs_n, ras_n, cas_n, we_n;
    logic bk_open, busy, dll_off, fast;
    lpd_state_e state;
    logic sref, pwr_dn, dn_act, dll_en, dll_rst, iclk_en;
    logic buf_en, rcv_en, ign, ref_p;
    int miscompares = 0;
    int cmp_count = 0;
    int n;
    initial begin
        forever #50 clk = ~clk;
    end
    lpd_ctl_model u_ctl (.i_clk(clk), .o_cke(cke), .o_cs_n(cs_n),
        .o_ras_n(ras_n), .o_cas_n(cas_n), .o_we_n(we_n));
    lpd_low_power u_dut (.i_clk(clk), .i_rst_n(rst_n), .i_cke(cke),
        .i_cs_n(cs_n), .i_ras_n(ras_n), .i_cas_n(cas_n), .i_we_n(we_n),
        .i_banks_open(bk_open), .i_busy(busy), .i_dll_disable(dll_off),
        .i_dn_fast_exit(fast), .o_state(state), .o_self_refresh(sref),
        .o_power_down(pwr_dn), .o_dn_active(dn_act), .o_dll_enable(dll_en),
        .o_dll_reset(dll_rst), .o_int_clk_en(iclk_en), .o_buf_en(buf_en),
        .o_cmd_rcv_en(rcv_en), .o_ctrl_ignore(ign), .o_refresh_pulse(ref_p));
    // ==========================================================
    // Helpers
    task automatic test_done();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Inputs change and outputs are read 10 ns after the edge
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #10;
    endtask
    task automatic wait_any(input logic [4:0] m);
        n = 0;
        while ((state & m) === 5'h00) begin
            cyc(1);
            n++;
            if (n > 200) begin
                miscompares++;
                test_done();
            end
        end
    endtask
    task automatic to_pulse();
        n = 0;
        do begin
            cyc(1);
            n++;
        end while (ref_p !== 1'b1 && n < 200);
        if (ref_p !== 1'b1) begin
            miscompares++;
            test_done();
        end
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_sref(input logic off);
        dll_off = off;
        cyc(2);
        chk(dll_en, !off);
        u_ctl.sr_enter();
        wait_any(5'h02);
        chk(state, LPD_ST_SREF);
        chk(sref, 1'b1);
        chk(iclk_en, 1'b0);
        chk(ign, 1'b1);
        chk(rcv_en, 1'b0);
        chk(dll_en, 1'b0);
        to_pulse();
        chk(n[7:0], 8'(`LPD_TCKE_CYC));
        to_pulse();
        chk(n[7:0], 8'(`LPD_TREFI_CYC + 1));
        chk(state, LPD_ST_SREF);
        u_ctl.sr_exit();
        wait_any(5'h01);
        chk(dll_rst, !off);
        chk(dll_en, !off);
        chk(iclk_en, 1'b1);
        cyc(1);
        chk(dll_rst, 1'b0);
    endtask
    task automatic t_pwr_dn();
        lpd_state_e e;
        dll_off = 1'b0;
        for (int i = 0; i < 3; i++) begin
            bk_open = (i == 0);
            fast = (i == 1);
            e = (i == 0) ? LPD_ST_DN_ACT : (i == 1) ? LPD_ST_DN_FAST :
                LPD_ST_DN_SLOW;
            u_ctl.dn_enter();
            wait_any(5'h1c);
            chk(state, e);
            chk(pwr_dn, 1'b1);
            chk(dn_act, i == 0);
            chk(dll_en, i != 2);
            chk(buf_en, 1'b0);
            chk(rcv_en, 1'b1);
            cyc(2);
            chk(rcv_en, 1'b0);
            u_ctl.dn_exit_bad();
            cyc(3);
            chk(state, e);
            u_ctl.dn_exit();
            wait_any(5'h01);
            chk(buf_en, 1'b1);
            chk(dll_en, 1'b1);
        end
    endtask
    // Class follows the banks while commands finish, then freezes
    task automatic t_busy();
        busy = 1'b1;
        bk_open = 1'b1;
        fast = 1'b1;
        u_ctl.dn_enter();
        wait_any(5'h1c);
        chk(state, LPD_ST_DN_ACT);
        bk_open = 1'b0;
        cyc(2);
        chk(state, LPD_ST_DN_FAST);
        busy = 1'b0;
        cyc(1);
        bk_open = 1'b1;
        cyc(2);
        chk(state, LPD_ST_DN_FAST);
        u_ctl.dn_exit();
        wait_any(5'h01);
    endtask
    task automatic t_rst();
        u_ctl.dn_enter();
        wait_any(5'h1c);
        rst_n = 1'b0;
        #1;
        chk(state, LPD_ST_IDLE);
        chk(pwr_dn, 1'b0);
        u_ctl.dn_exit();
        rst_n = 1'b1;
        cyc(4);
        chk(state, LPD_ST_IDLE);
    endtask
    initial begin
        rst_n = 1'b0;
        bk_open = 1'b0;
        busy = 1'b0;
        dll_off = 1'b0;
        fast = 1'b0;
        cyc(8);
        rst_n = 1'b1;
        cyc(4);
        chk(state, LPD_ST_IDLE);
        chk({buf_en, rcv_en, iclk_en, sref, ign, ref_p}, 8'h38);
        t_sref(1'b0);
        t_sref(1'b1);
        t_pwr_dn();
        t_busy();
        t_rst();
        test_done();
    end
endmodule
`default_nettype wire

//--- sim/lpd_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
module lpd_ctl_model #(
    parameter int TCKE = 1,   // Least time at each cke level
    parameter int TCKESR = 2, // Least self-refresh stay
    parameter int TXSDLL = 8, // Exit to locked-DLL command
    parameter int TXP = 3,    // Power-down exit latency
    parameter int TRFC = 4    // Refresh to next valid command
) (
    input wire logic i_clk,   // Core clock
    output var logic o_cke,   // Clock enable
    output var logic o_cs_n,  // Chip select, active low
    output var logic o_ras_n, // Row strobe, active low
    output var logic o_cas_n, // Column strobe, active low
    output var logic o_we_n   // Write enable, active low
);
    // ==========================================================
    // Command pins as {cs, ras, cas, we}
    logic in_sr = 1'b0;
    int gap = 0;
    initial begin
        o_cke = 1'b1;
        {o_cs_n, o_ras_n, o_cas_n, o_we_n} = 4'hf;
    end
    // Waits out the hold owed to the previous request first
    task automatic put(input logic c, input logic [3:0] cmd);
        repeat (gap) @(posedge i_clk);
        @(posedge i_clk);
        #10;
        gap = 0;
        o_cke = c;
        {o_cs_n, o_ras_n, o_cas_n, o_we_n} = cmd;
    endtask
    // ==========================================================
    // Pins are don't-care in self-refresh, so keep ras and we moving
    always @(posedge i_clk) begin
        #10;
        if (in_sr) begin
            o_ras_n = ~o_ras_n;
            o_we_n = ~o_we_n;
        end
    end
    task automatic sr_enter();
        put(1'b1, 4'h1);
        gap = TRFC;
        // Termination is never raised here, so it is off at entry
        put(1'b1, 4'h7);
        put(1'b0, 4'h1);
        // Pins may only go don't-care once entry has been registered
        @(posedge i_clk);
        #10;
        in_sr = 1'b1;
        gap = TCKESR;
    endtask
    task automatic sr_exit();
        in_sr = 1'b0;
        put(1'b1, 4'h7);
        // No write ever follows, so the reference-supply wait holds
        gap = TXSDLL;
    endtask
    // Entry only from a NOP, never inside a read, write or mode write
    task automatic dn_enter();
        put(1'b0, 4'h7);
        gap = TCKE;
    endtask
    // Commanded fault: cke high with an activate instead of a NOP
    task automatic dn_exit_bad();
        put(1'b1, 4'h3);
    endtask
    task automatic dn_exit();
        put(1'b1, 4'h7);
        gap = TXP;
    endtask
endmodule
`default_nettype wire
